//--- rtl/uss_map.vh
// Register addresses, field positions and reset values of the serial shift unit.
`ifndef USS_MAP_VH
`define USS_MAP_VH
`define USS_ADDR_CONTROL 2'h0
`define USS_ADDR_STATUS 2'h1
`define USS_ADDR_DATA 2'h2
`define USS_ADDR_BUFFER 2'h3
`define USS_CTL_START_IE 7
`define USS_CTL_OVF_IE 6
`define USS_CTL_WIRE_HI 5
`define USS_CTL_WIRE_LO 4
`define USS_CTL_CS_HI 3
`define USS_CTL_CS_LO 2
`define USS_CTL_STROBE 1
`define USS_CTL_TOGGLE 0
`define USS_ST_START 7
`define USS_ST_OVF 6
`define USS_ST_STOP 5
`define USS_ST_COLL 4
`define USS_WIRE_OFF 2'h0
`define USS_WIRE_THREE 2'h1
`define USS_WIRE_TWO 2'h2
`define USS_WIRE_TWO_HOLD 2'h3
`define USS_CS_NONE 2'h0
`define USS_CS_TIMER 2'h1
`define USS_ZERO8 8'h00
`define USS_ZERO4 4'h0
`define USS_CNT_ONE 4'h1
`define USS_CNT_MAX 4'hf
`endif

//--- rtl/uss_core.v
// Universal serial shift unit: shift data, buffer, counter, flags and line control.
`timescale 1ns/100ps
`include "uss_map.vh"
// Summary of operation
// - Source 00 strobe or none; 01 timer.
// - External: data one edge, counter both.
// - External source: strobe bit selects counter clock.
// - Source 00: strobe write shifts data and counts once.
// - Strobe and toggle bits always read zero.
// - Toggle write inverts clock port value.
// - External plus strobe: toggle clocks counter.
// - Start flag: start condition, or clock edge.
// - Start flag interrupt, cleared by one, releases hold.
// - Start interrupt wakes from every sleep.
// - Overflow flag on wrap, interrupt, write-one clear.
// - Overflow interrupt wakes from idle only.
// - Stop flag in two-wire, no interrupt.
// - Collision when bit 7 differs from pin.
// - Counter readable and writable in status.
// - Inputs feed unit even with outputs off.
// - Write wins over simultaneous shift.
// - Output latch transparent per clock source.
// - Completed transfer copies data into buffer.
// - Two-wire start holds clock line low.
// - Hold mode also holds clock on overflow.
module uss_core (
	// System clock and reset.
	input wire clock,
	input wire reset_n,
	// Register port.
	input wire [1:0] regAddr,
	input wire [7:0] regWrData,
	input wire regWrite,
	input wire regRead,
	output reg [7:0] regRdData_reg,
	// Timer compare match pulse and global interrupt enable, same clock.
	input wire timerMatch,
	input wire globalIntEnable,
	// Pin direction settings for the clock and data pins.
	input wire clkPinDirOut,
	input wire dataPinDirOut,
	// Serial clock pin, open drain in two-wire modes.
	input wire serialClkPinIn,
	output reg serialClkPinOut_reg,
	output reg serialClkPinOe_reg,
	// Serial data input pin, also the two-wire data line.
	input wire serialInPinIn,
	output reg serialInPinOut_reg,
	output reg serialInPinOe_reg,
	// Three-wire data output pin.
	output reg dataOutPin_reg,
	output reg dataOutPinOe_reg,
	// Interrupt requests and wake requests.
	output reg startIrq_reg,
	output reg ovfIrq_reg,
	output reg wakeAnySleep_reg,
	output reg wakeIdle_reg
);
	reg [7:0] control_reg;
	reg [7:0] shiftData_reg;
	reg [7:0] shiftBuffer_reg;
	reg [3:0] transferCounter_reg;
	reg startCondFlag_reg;
	reg countOvfFlag_reg;
	reg stopCondFlag_reg;
	reg clkPort_reg;
	reg startHold_reg;
	reg ovfHold_reg;
	reg outLatch_reg;
	reg dataSample_reg;
	reg [1:0] clkSync_reg;
	reg [1:0] dataSync_reg;
	reg clkPrev_reg;
	reg dataPrev_reg;

	wire [1:0] clkSrcSel = control_reg[`USS_CTL_CS_HI:`USS_CTL_CS_LO];
	wire [1:0] wireSel = control_reg[`USS_CTL_WIRE_HI:`USS_CTL_WIRE_LO];
	wire softClkStrobe = control_reg[`USS_CTL_STROBE];
	wire extSrc = clkSrcSel[1];
	wire twoWire = wireSel[1];
	wire clkLine = clkSync_reg[1];
	wire dataLine = dataSync_reg[1];
	wire clkRise = clkLine & ~clkPrev_reg;
	wire clkFall = ~clkLine & clkPrev_reg;

	// Register decode shared by writes and write-one clears.
	function wrHit;
		input [1:0] addr;
		input [1:0] target;
		input we;
		begin
			wrHit = we & (addr == target);
		end
	endfunction

	wire wrCtl = wrHit(regAddr, `USS_ADDR_CONTROL, regWrite);
	wire wrSt = wrHit(regAddr, `USS_ADDR_STATUS, regWrite);
	wire wrData = wrHit(regAddr, `USS_ADDR_DATA, regWrite);
	wire strobeWr = wrCtl & regWrData[`USS_CTL_STROBE];
	wire toggleWr = wrCtl & regWrData[`USS_CTL_TOGGLE];

	// Shift clock selection.
	reg shiftClk;
	reg countClk;
	always @* begin
		shiftClk = 1'b0;
		countClk = 1'b0;
		if (extSrc) begin
			shiftClk = clkSrcSel[0] ? clkFall : clkRise;
			if (softClkStrobe) begin
				countClk = toggleWr;
			end else begin
				countClk = clkRise | clkFall;
			end
		end else if (clkSrcSel == `USS_CS_TIMER) begin
			shiftClk = timerMatch;
			countClk = timerMatch;
		end else begin
			shiftClk = strobeWr;
			countClk = strobeWr;
		end
	end

	// A counter write in the same cycle as a count takes the written value.
	wire countWrap = countClk & ~wrSt & (transferCounter_reg == `USS_CNT_MAX);
	wire [7:0] shiftNext = {shiftData_reg[6:0], dataSample_reg};
	wire shiftEff = shiftClk & ~wrData;
	wire [7:0] dataNext = wrData ? regWrData : (shiftEff ? shiftNext : shiftData_reg);

	// Two-wire bus conditions seen on the synchronised lines.
	wire startCond = twoWire & clkLine & dataPrev_reg & ~dataLine;
	wire stopCond = twoWire & clkLine & ~dataPrev_reg & dataLine;
	wire startEvent = twoWire ? startCond : (clkRise | clkFall);
	wire startClr = wrSt & regWrData[`USS_ST_START];
	wire ovfClr = wrSt & regWrData[`USS_ST_OVF];
	wire stopClr = wrSt & regWrData[`USS_ST_STOP];
	wire startFlagNext = startEvent | (startCondFlag_reg & ~startClr);
	wire ovfFlagNext = countWrap | (countOvfFlag_reg & ~ovfClr);
	wire clkPortNext = toggleWr ? ~clkPort_reg : clkPort_reg;
	wire startHoldNext = (startCond & clkPinDirOut) | (startHold_reg & ~startClr);
	wire ovfHoldNext = (countWrap & (wireSel == `USS_WIRE_TWO_HOLD))
		| (ovfHold_reg & ~ovfClr);
	wire holdLow = twoWire & (startHoldNext | ovfHoldNext);
	// The output latch follows bit 7 while open; with an external clock it is
	// open only in the first half of the serial clock, so data changes away
	// from the sampling edge.
	wire latchOpen = ~extSrc | (clkSrcSel[0] ? clkLine : ~clkLine);
	wire latchNext = latchOpen ? dataNext[7] : outLatch_reg;

	reg [7:0] rdMux;
	always @* begin
		rdMux = `USS_ZERO8;
		case (regAddr)
			`USS_ADDR_CONTROL: begin
				rdMux = {control_reg[7:2], 2'b00};
			end
			`USS_ADDR_STATUS: begin
				rdMux = {startCondFlag_reg, countOvfFlag_reg, stopCondFlag_reg,
					shiftData_reg[7] ^ dataLine, transferCounter_reg};
			end
			`USS_ADDR_DATA: begin
				rdMux = shiftData_reg;
			end
			`USS_ADDR_BUFFER: begin
				rdMux = shiftBuffer_reg;
			end
			default: begin
				rdMux = `USS_ZERO8;
			end
		endcase
	end

	// Pins cross two flip-flops before any logic looks at them.
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			clkSync_reg <= 2'b00;
			dataSync_reg <= 2'b00;
		end else begin
			clkSync_reg <= {clkSync_reg[0], serialClkPinIn};
			dataSync_reg <= {dataSync_reg[0], serialInPinIn};
		end
	end

	// Line history for edge and bus condition detection.
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			clkPrev_reg <= 1'b0;
			dataPrev_reg <= 1'b0;
		end else begin
			clkPrev_reg <= clkLine;
			dataPrev_reg <= dataLine;
		end
	end

	// The input is sampled one cycle ahead of the shift it feeds.
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			dataSample_reg <= 1'b0;
		end else begin
			dataSample_reg <= dataLine;
		end
	end

	// The strobe bit is kept only where it selects the counter clock.
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			control_reg <= `USS_ZERO8;
		end else begin
			if (wrCtl) begin
				control_reg <= {regWrData[7:2], 2'b00} |
					{6'b000000, regWrData[`USS_CTL_STROBE] & regWrData[`USS_CTL_CS_HI], 1'b0};
			end
		end
	end

	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			shiftData_reg <= `USS_ZERO8;
		end else begin
			shiftData_reg <= dataNext;
		end
	end

	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			transferCounter_reg <= `USS_ZERO4;
		end else begin
			if (wrSt) begin
				transferCounter_reg <= regWrData[3:0];
			end else if (countClk) begin
				transferCounter_reg <= transferCounter_reg + `USS_CNT_ONE;
			end
		end
	end

	// Loading on the wrap edge keeps the copy free of the next shift.
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			shiftBuffer_reg <= `USS_ZERO8;
		end else begin
			if (countWrap) begin
				shiftBuffer_reg <= dataNext;
			end
		end
	end

	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			startCondFlag_reg <= 1'b0;
		end else begin
			startCondFlag_reg <= startFlagNext;
		end
	end

	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			countOvfFlag_reg <= 1'b0;
		end else begin
			countOvfFlag_reg <= ovfFlagNext;
		end
	end

	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			stopCondFlag_reg <= 1'b0;
		end else begin
			stopCondFlag_reg <= stopCond | (stopCondFlag_reg & ~stopClr);
		end
	end

	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			clkPort_reg <= 1'b0;
		end else begin
			clkPort_reg <= clkPortNext;
		end
	end

	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			startHold_reg <= 1'b0;
		end else begin
			startHold_reg <= startHoldNext;
		end
	end

	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			ovfHold_reg <= 1'b0;
		end else begin
			ovfHold_reg <= ovfHoldNext;
		end
	end

	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			outLatch_reg <= 1'b0;
		end else begin
			outLatch_reg <= latchNext;
		end
	end

	// Read data stand for one cycle only, so an idle bus reads zero.
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			regRdData_reg <= `USS_ZERO8;
		end else begin
			regRdData_reg <= regRead ? rdMux : `USS_ZERO8;
		end
	end

	// Interrupt requests come from the flags after this edge.
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			startIrq_reg <= 1'b0;
			ovfIrq_reg <= 1'b0;
		end else begin
			startIrq_reg <= startFlagNext & control_reg[`USS_CTL_START_IE] & globalIntEnable;
			ovfIrq_reg <= ovfFlagNext & control_reg[`USS_CTL_OVF_IE] & globalIntEnable;
		end
	end

	// Wake requests ignore the global enable so a sleeping core still hears them.
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			wakeAnySleep_reg <= 1'b0;
			wakeIdle_reg <= 1'b0;
		end else begin
			wakeAnySleep_reg <= startFlagNext & control_reg[`USS_CTL_START_IE];
			wakeIdle_reg <= ovfFlagNext & control_reg[`USS_CTL_OVF_IE];
		end
	end

	// Two-wire lines are open drain: only a low is ever driven.
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			serialClkPinOut_reg <= 1'b0;
			serialClkPinOe_reg <= 1'b0;
		end else begin
			if (twoWire) begin
				serialClkPinOut_reg <= 1'b0;
				serialClkPinOe_reg <= clkPinDirOut & (~clkPortNext | holdLow);
			end else begin
				serialClkPinOut_reg <= clkPortNext;
				serialClkPinOe_reg <= clkPinDirOut;
			end
		end
	end

	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			serialInPinOut_reg <= 1'b0;
			serialInPinOe_reg <= 1'b0;
		end else begin
			serialInPinOut_reg <= 1'b0;
			if (twoWire) begin
				serialInPinOe_reg <= dataPinDirOut & ~latchNext;
			end else begin
				serialInPinOe_reg <= 1'b0;
			end
		end
	end

	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			dataOutPin_reg <= 1'b0;
			dataOutPinOe_reg <= 1'b0;
		end else begin
			if (twoWire) begin
				dataOutPin_reg <= 1'b0;
				dataOutPinOe_reg <= 1'b0;
			end else begin
				dataOutPin_reg <= latchNext;
				dataOutPinOe_reg <= dataPinDirOut & (wireSel == `USS_WIRE_THREE);
			end
		end
	end
endmodule

//--- verif/uss_checker.sv
// Port checker of the serial shift unit.
`timescale 1ns/100ps
module uss_checker (
	// Clock, reset and register port.
	input wire clock,
	input wire reset_n,
	input wire [1:0] regAddr,
	input wire [7:0] regWrData,
	input wire regWrite,
	input wire regRead,
	input wire [7:0] regRdData_reg,
	// Gates and requests.
	input wire globalIntEnable,
	input wire startIrq_reg,
	input wire ovfIrq_reg,
	input wire wakeAnySleep_reg,
	input wire wakeIdle_reg
);
	// Source mirror; external edges could otherwise move the counter under a check.
	reg [1:0] srcReg;
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			srcReg <= 2'h0;
		end else if (regWrite && regAddr == 2'h0) begin
			srcReg <= regWrData[3:2];
		end
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);
	sequence cntWr; regWrite && regAddr == 2'h1 && srcReg == 2'h0; endsequence
	sequence stRd; regRead && regAddr == 2'h1; endsequence
	sequence strobeWr; regWrite && regAddr == 2'h0 && regWrData[3:1] == 3'h1 && srcReg == 2'h0;
	endsequence
	cnt_readback_a: assert property (cntWr ##1 stRd |=>
		regRdData_reg[3:0] == $past(regWrData[3:0], 2)) else $error("counter readback wrong");
	strobe_count_a: assert property (cntWr ##1 strobeWr ##1 stRd |=>
		regRdData_reg[3:0] == $past(regWrData[3:0], 3) + 4'h1) else $error("strobe count wrong");
	strobe_zero_a: assert property (regRead && regAddr == 2'h0 |=>
		regRdData_reg[1:0] == 2'h0) else $error("strobe bits not zero");
	idle_rdata_a: assert property (!regRead |=> regRdData_reg == 8'h00)
		else $error("read data outside answer cycle");
	start_gate_a: assert property (startIrq_reg |->
		$past(globalIntEnable) && wakeAnySleep_reg) else $error("start request ungated");
	ovf_gate_a: assert property (ovfIrq_reg |->
		$past(globalIntEnable) && wakeIdle_reg) else $error("overflow request ungated");
	ovf_clear_a: assert property (cntWr and regWrData[6] |-> ##2 !wakeIdle_reg)
		else $error("overflow flag not cleared");
	start_clear_a: assert property (cntWr and regWrData[7] |-> ##2 !wakeAnySleep_reg)
		else $error("start flag not cleared");
endmodule
bind uss_core uss_checker uss_checker_i (.clock, .reset_n, .regAddr, .regWrData, .regWrite,
	.regRead, .regRdData_reg, .globalIntEnable, .startIrq_reg, .ovfIrq_reg, .wakeAnySleep_reg,
	.wakeIdle_reg);

//--- verif/uss_far_end.sv
// Far-end master that clocks one byte into the unit, MSB first.
`timescale 1ns/100ps
module uss_far_end (
	// Frame request and byte.
	input wire go,
	input wire [7:0] txByte,
	// Link clock, data and activity.
	output reg sclk,
	output reg sdo,
	output reg busy
);
	integer i;
	initial begin
		sclk = 1'b0;
		sdo = 1'b0;
		busy = 1'b0;
	end
	// The clock stands low between frames, so idle time sets no start flag.
	always @(posedge go) begin
		busy = 1'b1;
		#37;
		for (i = 7; i >= 0; i = i - 1) begin
			sdo = txByte[i];
			#400 sclk = 1'b1;
			#400 sclk = 1'b0;
		end
		sdo = ~sdo;
		busy = 1'b0;
	end
endmodule

//--- verif/universal_serial_shift_unit_test.sv
// Self-checking bench of the serial shift unit.
`timescale 1ns/100ps
`include "uss_map.vh"
module universal_serial_shift_unit_test;
	reg clock, reset_n, regWrite, regRead, timerMatch, globalIntEnable, benchBit, go;
	reg [1:0] regAddr;
	reg [7:0] regWrData, txByte, q, mData;
	reg [31:0] seed;
	wire [7:0] regRdData_reg;
	wire clkOut, clkOe, datOut, datOe, sclk, sdo, busy, sIrq, oIrq, wAny, wIdle, dOut;
	wire serialClkPinIn = clkOe ? clkOut : sclk;
	wire serialInPinIn = datOe ? datOut : (busy ? sdo : benchBit);
	integer errors, check_count, cyc, i;
	uss_core uss_core_i (.clock, .reset_n, .regAddr, .regWrData, .regWrite, .regRead,
		.regRdData_reg, .timerMatch, .globalIntEnable, .clkPinDirOut(1'b0), .dataPinDirOut(1'b0),
		.serialClkPinIn, .serialClkPinOut_reg(clkOut), .serialClkPinOe_reg(clkOe), .serialInPinIn,
		.serialInPinOut_reg(datOut), .serialInPinOe_reg(datOe), .dataOutPin_reg(dOut),
		.dataOutPinOe_reg(), .startIrq_reg(sIrq), .ovfIrq_reg(oIrq), .wakeAnySleep_reg(wAny),
		.wakeIdle_reg(wIdle));
	uss_far_end uss_far_end_i (.go, .txByte, .sclk, .sdo, .busy);
	function [31:0] lfsr(input [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// One bus cycle; q holds the answer cycle's read data.
	task bus(input w, input [1:0] a, input [7:0] d);
		regWrite <= w;
		regRead <= !w;
		regAddr <= a;
		regWrData <= d;
		@(posedge clock);
		#1;
		q = regRdData_reg;
	endtask
	task idle(input integer n);
		regWrite <= 1'b0;
		regRead <= 1'b0;
		repeat (n) @(posedge clock);
		#1;
	endtask
	task chk(input [63:0] nm, input [7:0] e, input [7:0] g);
		check_count = check_count + 1;
		if (g !== e) begin
			errors = errors + 1;
			$display("[ERR] %0s expected %h seen %h", nm, e, g);
		end
	endtask
	task give_verdict;
		if (errors == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	always @(posedge clock) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			errors = errors + 1;
			give_verdict;
		end
	end
	initial begin
		{errors, check_count, cyc} = 0;
		{regAddr, regWrData, regWrite, regRead, timerMatch, globalIntEnable, go, txByte} = 0;
		benchBit = 1'b1;
		seed = 32'hec80af1c;
		reset_n = 1'b0;
		repeat (16) @(posedge clock);
		#1;
		reset_n = 1'b1;
		for (i = 0; i < 4; i = i + 1) begin
			seed = lfsr(seed);
			bus(1, `USS_ADDR_STATUS, {4'he, seed[3:0]});
			bus(0, `USS_ADDR_STATUS, 8'h00);
			chk("count", seed[3:0], q[3:0]);
		end
		bus(1, `USS_ADDR_STATUS, 8'he5);
		bus(1, `USS_ADDR_CONTROL, 8'h02);
		bus(0, `USS_ADDR_STATUS, 8'h00);
		chk("strobe", 8'h06, q[3:0]);
		seed = lfsr(seed);
		mData = seed[15:8];
		bus(1, `USS_ADDR_DATA, mData);
		bus(1, `USS_ADDR_STATUS, 8'he0);
		for (i = 0; i < 16; i = i + 1) begin
			seed = lfsr(seed);
			benchBit <= seed[0];
			idle(4);
			bus(1, `USS_ADDR_CONTROL, 8'h03);
			mData = {mData[6:0], benchBit};
		end
		bus(0, `USS_ADDR_DATA, 8'h00);
		chk("data", mData, q);
		chk("dout", {7'h00, mData[7]}, {7'h00, dOut});
		bus(0, `USS_ADDR_BUFFER, 8'h00);
		chk("buffer", mData, q);
		bus(0, `USS_ADDR_STATUS, 8'h00);
		chk("status", {3'h2, mData[7] ^ benchBit, 4'h0}, q);
		bus(1, `USS_ADDR_CONTROL, 8'h08);
		bus(1, `USS_ADDR_STATUS, 8'he0);
		seed = lfsr(seed);
		txByte <= seed[7:0];
		go <= 1'b1;
		idle(2);
		go <= 1'b0;
		for (i = 0; i < 200 && busy; i = i + 1) idle(1);
		idle(5);
		bus(0, `USS_ADDR_DATA, 8'h00);
		chk("extdata", txByte, q);
		bus(0, `USS_ADDR_STATUS, 8'h00);
		chk("extstat", {3'h6, txByte[7] ^ benchBit, 4'h0}, q);
		bus(0, `USS_ADDR_BUFFER, 8'h00);
		chk("extbuf", txByte, q);
		globalIntEnable <= 1'b1;
		bus(1, `USS_ADDR_CONTROL, 8'hc0);
		idle(2);
		chk("irq", 8'h0f, {sIrq, oIrq, wAny, wIdle});
		globalIntEnable <= 1'b0;
		idle(2);
		chk("masked", 8'h03, {sIrq, oIrq, wAny, wIdle});
		bus(1, `USS_ADDR_STATUS, 8'h40);
		idle(2);
		chk("cleared", 8'h02, {sIrq, oIrq, wAny, wIdle});
		bus(1, `USS_ADDR_CONTROL, 8'h00);
		bus(1, `USS_ADDR_STATUS, 8'he0);
		seed = lfsr(seed);
		for (i = 0; i < 8; i = i + 1) begin
			timerMatch <= i > 2;
			if (i == 7) bus(1, `USS_ADDR_DATA, seed[7:0]);
			else if (i == 3) bus(1, `USS_ADDR_CONTROL, 8'h04);
			else idle(1);
			timerMatch <= 1'b0;
			idle(1);
		end
		bus(0, `USS_ADDR_STATUS, 8'h00);
		chk("timer", 8'h04, q[3:0]);
		bus(0, `USS_ADDR_DATA, 8'h00);
		chk("wrwins", seed[7:0], q);
		bus(1, `USS_ADDR_CONTROL, 8'h0a);
		bus(1, `USS_ADDR_STATUS, 8'he0);
		repeat (3) bus(1, `USS_ADDR_CONTROL, 8'h0b);
		bus(0, `USS_ADDR_STATUS, 8'h00);
		chk("toggle", 8'h03, q[3:0]);
		bus(0, `USS_ADDR_CONTROL, 8'h00);
		chk("ctlread", 8'h00, q[1:0]);
		give_verdict;
	end
endmodule
